// ### logic/scu_defines.svh
// command codes, field positions, register offsets and timing for the speech command link
//
// How it works
// - channel commands with empty mask are dropped
// - volume applies to every named channel
// - host holds data line low during readback
// - host repeats empty error read when flagged
// - safety enables reset to stopped state
// - watchdog plus fault-reset keeps fault-reset only
// - audio channel command needs other channels idle
// - left-to-right switch passes through both off
// - format commands ignored while port enabled
// - order is format, clocks, silence, channel
// - silence channel differs from audio channels
// - transmit and receive formats decode alike
`ifndef SCU_DEFINES_SVH
`define SCU_DEFINES_SVH

// opcode is the upper nibble of the first byte, channel mask the lower
`define SCU_OP_VOL     4'h1
`define SCU_OP_SIL     4'h2
`define SCU_OP_SAFE    4'h3
`define SCU_OP_OSEL    4'h4
`define SCU_OP_ACH     4'h5
`define SCU_OP_AFMT    4'h6
`define SCU_OP_ATX     4'h7
`define SCU_OP_ARX     4'h8
`define SCU_OP_RSTAT   4'h9
`define SCU_OP_RVER    4'ha
`define SCU_OP_RERR    4'hb

// data byte fields
`define SCU_SAFE_WDT   0
`define SCU_SAFE_FRST  1
`define SCU_EN_L       1
`define SCU_EN_R       0

// bit counter marks inside a 16-bit frame
`define SCU_OPC_BIT    4'h7
`define SCU_LAST_BIT   4'hf

// host register offsets (haddr[3:0]) and status bits
`define SCU_HREG_CMD   4'h0
`define SCU_HREG_STAT  4'h4
`define SCU_STAT_REFUSED 1

// timing
`define SCU_HCLK_NS     40
`define SCU_MS_NS       1000000
`define SCU_LEAD_MS     12'd10
`define SCU_SIL_UNIT_MS 12'd5
`define SCU_RETRY_MAX   2'd3
`define SCU_HALF_CYC    4

`endif

// ### logic/scu_pkg.sv
// types shared by both ends of the speech command link
`include "scu_defines.svh"
package scu_pkg;

	typedef struct packed {
		logic [3:0] spare;
		logic       lsb_first;
		logic       delay1;
		logic       lr_inv;
		logic       len16;
	} scu_fmt_t;

	function automatic scu_fmt_t scu_fmt_decode(input logic [7:0] b);
		return scu_fmt_t'(b);
	endfunction : scu_fmt_decode

	typedef struct packed {
		logic [3:0]      bitc;
		logic [7:0]      sh;
		logic [7:0]      op;
		logic [7:0]      outb;
		logic [3:0][6:0] vol;
		logic [3:0]      safe;
		logic            outsel;
		logic            len;
		logic            ren;
		logic [3:0]      amask;
		scu_fmt_t        fmt;
		scu_fmt_t        txf;
		scu_fmt_t        rxf;
		logic [3:0]      smask;
		logic [7:0]      slen;
		logic            st1;
		logic            st2;
		logic [3:0]      idle_m;
		logic [3:0]      idle_s;
		logic [7:0]      err_m;
		logic [7:0]      err_s;
	} scu_dev_st_t;

	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} scu_hph_t;

	typedef struct packed {
		scu_hph_t    ph;
		logic [7:0]  div;
		logic [3:0]  bitn;
		logic [15:0] tx;
		logic [15:0] cur;
		logic [15:0] last;
		logic        pend2;
		logic [7:0]  rx;
		logic        sclk;
		logic        sel_n;
		logic        si;
		logic        so_m;
		logic        so_s;
		logic        p1_m;
		logic        p1_s;
		logic        p2_m;
		logic        p2_s;
		logic        a_ok;
		logic        a_wr;
		logic [3:0]  a_off;
		logic [31:0] rdata;
		logic        rdy;
		logic        refused;
		logic        retried;
		logic [1:0]  retries;
		logic [1:0]  cur_en;
		logic [3:0]  smask;
		logic        fmt_done;
		logic        sil_done;
		logic        outsel;
		logic        clk_en;
		logic [3:0]  idle;
		logic [23:0] ms_cnt;
		logic [11:0] sil_ms;
	} scu_host_st_t;

endpackage : scu_pkg

// ### logic/scu_link_if.sv
// serial command link between host controller and speech device
`timescale 1ns/100ps
interface scu_link_if;
	logic link_clk;
	logic sel_n;
	logic cmd_din;
	logic rsp_dout;
	logic status_out_pin_one;
	logic status_out_pin_two;

	modport host (
		output link_clk,
		output sel_n,
		output cmd_din,
		input  rsp_dout,
		input  status_out_pin_one,
		input  status_out_pin_two
	);

	modport dev (
		input  link_clk,
		input  sel_n,
		input  cmd_din,
		output rsp_dout,
		output status_out_pin_one,
		output status_out_pin_two
	);
endinterface : scu_link_if

// ### logic/scu_dev.sv
// speech device command decoder, clocked by the link clock
`timescale 1ns/100ps
`include "scu_defines.svh"
module scu_dev
	import scu_pkg::*;
#(
	parameter logic [7:0] VERSION = 8'h5a // arbitrary value
)(
	// reset
	input  wire logic            hresetn,
	// link
	scu_link_if.dev              lnk,
	// device core side
	input  wire logic [3:0]      channel_idle_flag,
	input  wire logic [7:0]      fault_code,
	output logic [3:0][6:0]      volume,
	output logic [3:0]           safety_en,
	output logic                 left_port_enable,
	output logic                 right_port_enable,
	output logic [3:0]           audio_chan_mask,
	output scu_fmt_t             audio_fmt,
	output scu_fmt_t             audio_tx_fmt,
	output scu_fmt_t             audio_rx_fmt,
	output logic [3:0]           silence_mask,
	output logic [7:0]           silence_len
);

	scu_dev_st_t q;
	scu_dev_st_t n;
	logic [7:0]  byte_in;
	logic [3:0]  mask;
	logic        chan_ok;

	always_comb
	begin
		n       = q;
		byte_in = {q.sh[6:0], lnk.cmd_din};
		mask    = q.op[3:0];
		chan_ok = (mask != 4'h0);
		n.idle_m = channel_idle_flag;
		n.idle_s = q.idle_m;
		n.err_m  = fault_code;
		n.err_s  = q.err_m;
		n.sh     = byte_in;
		// select high between frames realigns the bit count
		n.bitc   = lnk.sel_n ? 4'h0 : q.bitc + 4'h1;
		n.outb   = {q.outb[6:0], 1'b0};
		n.st1    = q.outsel ? |q.err_s[3:0] : ~&q.idle_s;
		n.st2    = q.outsel ? |q.err_s[7:4] : (q.len | q.ren);
		if (q.bitc == `SCU_OPC_BIT)
		begin
			n.op = byte_in;
			case (byte_in[7:4])
				`SCU_OP_RSTAT: n.outb = {2'b00, q.len, q.ren, q.idle_s};
				`SCU_OP_RVER:  n.outb = VERSION;
				`SCU_OP_RERR:  n.outb = q.err_s;
				default:        n.outb = 8'h00;
			endcase
		end
		if (q.bitc == `SCU_LAST_BIT)
		begin
			case (q.op[7:4])
				`SCU_OP_VOL:
				begin
					for (int i = 0; i < 4; i++)
					begin
						if (chan_ok && mask[i])
							n.vol[i] = byte_in[6:0];
					end
				end
				`SCU_OP_SIL:
				begin
					if (chan_ok)
					begin
						n.smask = mask;
						n.slen  = byte_in;
					end
				end
				`SCU_OP_SAFE:
				begin
					n.safe = byte_in[3:0];
					if (byte_in[`SCU_SAFE_WDT] && byte_in[`SCU_SAFE_FRST])
						n.safe[`SCU_SAFE_WDT] = 1'b0;
				end
				`SCU_OP_OSEL: n.outsel = byte_in[0];
				`SCU_OP_ACH:
				begin
					if (chan_ok)
					begin
						n.amask = mask;
						n.len   = byte_in[`SCU_EN_L];
						n.ren   = byte_in[`SCU_EN_R];
					end
				end
				`SCU_OP_AFMT:
				begin
					if (!(q.len || q.ren))
						n.fmt = scu_fmt_decode(byte_in);
				end
				`SCU_OP_ATX:
				begin
					if (!(q.len || q.ren))
						n.txf = scu_fmt_decode(byte_in);
				end
				`SCU_OP_ARX:
				begin
					if (!(q.len || q.ren))
						n.rxf = scu_fmt_decode(byte_in);
				end
				default: n.op = q.op;
			endcase
		end
	end

	// reset value of every field is zero: volumes off, safety stopped
	always_ff @(posedge lnk.link_clk or negedge hresetn)
	begin
		if (!hresetn)
			q <= '0;
		else
			q <= n;
	end

	assign lnk.rsp_dout           = q.outb[7];
	assign lnk.status_out_pin_one = q.st1;
	assign lnk.status_out_pin_two = q.st2;
	assign volume                 = q.vol;
	assign safety_en              = q.safe;
	assign left_port_enable       = q.len;
	assign right_port_enable      = q.ren;
	assign audio_chan_mask        = q.amask;
	assign audio_fmt              = q.fmt;
	assign audio_tx_fmt           = q.txf;
	assign audio_rx_fmt           = q.rxf;
	assign silence_mask           = q.smask;
	assign silence_len            = q.slen;

endmodule : scu_dev

// ### logic/scu_host.sv
// host controller: AHB-Lite registers in, serial command frames out
`timescale 1ns/100ps
`include "scu_defines.svh"
module scu_host
	import scu_pkg::*;
#(
	parameter int HALF   = `SCU_HALF_CYC,
	parameter int MS_CYC = `SCU_MS_NS / `SCU_HCLK_NS
)(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// link
	scu_link_if.host         lnk,
	// audio clock source control
	output logic             audio_clk_en
);

	scu_host_st_t q;
	scu_host_st_t n;
	logic         half;
	logic         start;
	logic [15:0]  frame;
	logic         new_cmd;
	logic [15:0]  w;
	logic [3:0]   wop;
	logic [3:0]   wm;
	logic [7:0]   wd;
	logic         rf;
	logic         busy;
	logic [3:0]   cop;
	logic [7:0]   cd;

	always_comb
	begin
		n       = q;
		start   = 1'b0;
		frame   = q.cur;
		half    = (q.div == 8'(HALF - 1));
		busy    = (q.ph != H_IDLE) || q.pend2;
		w       = hwdata[15:0];
		wop     = w[15:12];
		wm      = w[11:8];
		wd      = w[7:0];
		cop     = q.cur[15:12];
		cd      = q.cur[7:0];
		new_cmd = q.a_ok && q.a_wr && (q.a_off == `SCU_HREG_CMD);
		rf      = 1'b0;

		// pins from the device cross into hclk through two flops
		n.so_m = lnk.rsp_dout;
		n.so_s = q.so_m;
		n.p1_m = lnk.status_out_pin_one;
		n.p1_s = q.p1_m;
		n.p2_m = lnk.status_out_pin_two;
		n.p2_s = q.p2_m;

		// millisecond tick for the silence window
		if (q.ms_cnt == 24'(MS_CYC - 1))
		begin
			n.ms_cnt = 24'h0;
			if (q.sil_ms != 12'h0)
				n.sil_ms = q.sil_ms - 12'h1;
		end
		else
			n.ms_cnt = q.ms_cnt + 24'h1;

		// bus address phase; read data is prepared here so there are no waits
		n.a_ok  = hsel && htrans[1] && hready;
		n.a_wr  = hwrite;
		n.a_off = haddr[3:0];
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			case (haddr[3:0])
				`SCU_HREG_CMD:  n.rdata = {16'h0000, q.last};
				`SCU_HREG_STAT: n.rdata = {8'h00, q.cur_en, q.p2_s, q.p1_s, q.idle, q.rx,
					4'h0, q.clk_en, q.retried, q.refused, busy};
				default:        n.rdata = 32'h0000_0000;
			endcase
		end
		if (q.a_ok && q.a_wr && (q.a_off == `SCU_HREG_STAT) && hwdata[`SCU_STAT_REFUSED])
			n.refused = 1'b0;

		// command checks before anything goes on the link
		case (wop)
			`SCU_OP_VOL: rf = (wm == 4'h0);
			`SCU_OP_SIL: rf = (wm == 4'h0) || !q.fmt_done;
			`SCU_OP_ACH:
			begin
				rf = (wm == 4'h0);
				if (wd[`SCU_EN_L] || wd[`SCU_EN_R])
				begin
					rf = rf || !q.sil_done;
					rf = rf || (q.sil_ms < `SCU_LEAD_MS);
					rf = rf || ((wm & q.smask) != 4'h0);
					rf = rf || ((q.idle | wm) != 4'hf);
				end
			end
			`SCU_OP_AFMT, `SCU_OP_ATX, `SCU_OP_ARX:
				rf = (q.cur_en != 2'b00);
			`SCU_OP_SAFE:
				rf = wd[`SCU_SAFE_WDT] && wd[`SCU_SAFE_FRST];
			`SCU_OP_OSEL, `SCU_OP_RSTAT, `SCU_OP_RVER, `SCU_OP_RERR:
				rf = 1'b0;
			default: rf = 1'b1;
		endcase

		if (new_cmd)
		begin
			n.last = w;
			if (busy || rf)
				n.refused = 1'b1;
			else
			begin
				start     = 1'b1;
				n.retries = 2'b00;
				n.retried = 1'b0;
				frame     = w;
				if (wop == `SCU_OP_RSTAT || wop == `SCU_OP_RVER || wop == `SCU_OP_RERR)
					frame = {w[15:8], 8'h00};
				if (wop == `SCU_OP_ACH && q.cur_en == 2'b10 && wd[1:0] == 2'b01)
				begin
					n.pend2 = 1'b1;
					frame   = {w[15:8], wd & 8'hfc};
				end
			end
		end

		// frame sequencer: half periods of HALF hclk cycles each
		if (q.ph != H_IDLE)
		begin
			if (!half)
				n.div = q.div + 8'h01;
			else
				n.div = 8'h00;
		end
		case (q.ph)
			H_IDLE:  n.ph = H_IDLE;
			H_SETUP:
			begin
				if (half)
					n.ph = H_LOW;
			end
			H_LOW:
			begin
				if (half)
				begin
					n.sclk = 1'b1;
					n.ph   = H_HIGH;
					if (q.bitn[3])
						n.rx = {q.rx[6:0], q.so_s};
				end
			end
			H_HIGH:
			begin
				if (half)
				begin
					n.sclk = 1'b0;
					n.tx   = {q.tx[14:0], 1'b0};
					n.si   = q.tx[14];
					n.bitn = q.bitn + 4'h1;
					n.ph   = (q.bitn == `SCU_LAST_BIT) ? H_END : H_LOW;
					if (q.bitn == `SCU_LAST_BIT)
						n.si = 1'b0;
				end
			end
			H_END:
			begin
				if (half)
				begin
					n.sel_n = 1'b1;
					n.ph    = H_IDLE;
					// track what the device now holds
					case (cop)
						`SCU_OP_ACH:
						begin
							if (q.cur[11:8] != 4'h0)
								n.cur_en = cd[1:0];
						end
						`SCU_OP_AFMT:
						begin
							n.fmt_done = 1'b1;
							n.clk_en   = 1'b1;
						end
						`SCU_OP_SIL:
						begin
							n.sil_done = 1'b1;
							n.smask    = q.cur[11:8];
							n.sil_ms   = 12'(cd) * `SCU_SIL_UNIT_MS;
						end
						`SCU_OP_OSEL:  n.outsel = cd[0];
						`SCU_OP_RSTAT: n.idle = q.rx[3:0];
						default:         n.outsel = q.outsel;
					endcase
					if (q.pend2)
					begin
						n.pend2 = 1'b0;
						start   = 1'b1;
						frame   = q.last;
					end
					else if (cop == `SCU_OP_RERR && q.rx == 8'h00 && q.outsel
						&& (q.p1_s || q.p2_s) && q.retries != `SCU_RETRY_MAX)
					begin
						start     = 1'b1;
						n.retries = q.retries + 2'b01;
						n.retried = 1'b1;
					end
				end
			end
			default: n.ph = H_IDLE;
		endcase

		if (start)
		begin
			n.ph    = H_SETUP;
			n.sel_n = 1'b0;
			n.tx    = frame;
			n.cur   = frame;
			n.si    = frame[15];
			n.div   = 8'h00;
			n.bitn  = 4'h0;
			n.rx    = 8'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q       <= '0;
			q.rdy   <= 1'b1;
			q.sel_n <= 1'b1;
		end
		else
			q <= n;
	end

	assign hrdata       = q.rdata;
	assign hreadyout    = q.rdy;
	assign hresp        = 1'b0 & q.rdy;
	assign lnk.link_clk = q.sclk;
	assign lnk.sel_n    = q.sel_n;
	assign lnk.cmd_din  = q.si;
	assign audio_clk_en = q.clk_en;

endmodule : scu_host

// ### dv/scu_link_assertions.sv
// concurrent checks on the serial command link between host and device
`timescale 1ns/100ps
`include "scu_defines.svh"
module scu_link_assertions (
	// reset
	input wire logic hresetn,
	// link
	input wire logic link_clk,
	input wire logic sel_n,
	input wire logic cmd_din,
	input wire logic rsp_dout,
	input wire logic status_out_pin_one,
	input wire logic status_out_pin_two
);
	logic [3:0]  cnt_q;
	logic [14:0] sh_q;
	logic [1:0]  en_q;
	logic [3:0]  smask_q;
	logic        fmt_q;
	logic        sil_q;
	logic [15:0] w;
	logic        last;
	logic [3:0]  op;
	assign w = {sh_q, cmd_din};
	assign last = !sel_n && cnt_q == 4'hf;
	assign op = w[15:12];
	// frames are whole, so the bit counter wraps to zero at each frame end
	always_ff @(posedge link_clk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_q <= 4'h0;
			sh_q <= 15'h0;
			en_q <= 2'h0;
			smask_q <= 4'h0;
			fmt_q <= 1'b0;
			sil_q <= 1'b0;
		end
		else if (!sel_n)
		begin
			cnt_q <= cnt_q + 4'h1;
			sh_q <= w[14:0];
			if (last && op == `SCU_OP_ACH)
				en_q <= w[1:0];
			if (last && op == `SCU_OP_SIL)
				smask_q <= w[11:8];
			if (last && op == `SCU_OP_SIL)
				sil_q <= 1'b1;
			if (last && op == `SCU_OP_AFMT)
				fmt_q <= 1'b1;
		end
	end
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!hresetn);
	property p_mask_set;
		last && op inside {`SCU_OP_VOL, `SCU_OP_SIL, `SCU_OP_ACH} |-> w[11:8] != 4'h0;
	endproperty
	a_mask_set: assert property (p_mask_set)
		else $error("channel command sent with empty mask");
	property p_safe_pair;
		last && op == `SCU_OP_SAFE |-> w[1:0] != 2'b11;
	endproperty
	a_safe_pair: assert property (p_safe_pair)
		else $error("watchdog and fault reset sent together");
	property p_read_low;
		!sel_n && cnt_q == 4'h7 && sh_q[6:3] inside {`SCU_OP_RSTAT, `SCU_OP_RVER, `SCU_OP_RERR}
			|=> (!cmd_din)[*8];
	endproperty
	a_read_low: assert property (p_read_low)
		else $error("data line not low during readback byte");
	property p_fmt_off;
		last && op inside {`SCU_OP_AFMT, `SCU_OP_ATX, `SCU_OP_ARX} |-> en_q == 2'b00;
	endproperty
	a_fmt_off: assert property (p_fmt_off)
		else $error("format command sent while port enabled");
	property p_left_right;
		last && op == `SCU_OP_ACH && w[1:0] == 2'b01 |-> en_q != 2'b10;
	endproperty
	a_left_right: assert property (p_left_right)
		else $error("left to right switch without both off");
	property p_sil_order;
		last && op == `SCU_OP_SIL |-> fmt_q;
	endproperty
	a_sil_order: assert property (p_sil_order)
		else $error("silence sent before format");
	property p_chan_order;
		last && op == `SCU_OP_ACH && w[1:0] != 2'b00 |-> sil_q && fmt_q;
	endproperty
	a_chan_order: assert property (p_chan_order)
		else $error("audio channel enabled before silence");
	property p_sil_chan;
		last && op == `SCU_OP_ACH && w[1:0] != 2'b00 |-> (w[11:8] & smask_q) == 4'h0;
	endproperty
	a_sil_chan: assert property (p_sil_chan)
		else $error("audio channel overlaps silence channel");
endmodule : scu_link_assertions

// ### dv/speech_cmd_usage_checks_bench.sv
// self-checking bench: host and device joined over the command link
`timescale 1ns/100ps
`include "scu_defines.svh"
module speech_cmd_usage_checks_bench
	import scu_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, audio_clk_en;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  channel_idle_flag, safety_en, audio_chan_mask, silence_mask;
	logic [7:0]  fault_code, silence_len;
	logic [3:0][6:0] volume;
	logic        left_port_enable, right_port_enable;
	scu_fmt_t    audio_fmt, audio_tx_fmt, audio_rx_fmt;
	int          n_errors, samples_checked, cyc;

	scu_link_if scu_link_if_i ();
	// short millisecond keeps the silence window inside the run
	scu_host #(.HALF(4), .MS_CYC(20)) scu_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.lnk(scu_link_if_i.host), .audio_clk_en);
	scu_dev scu_dev_i (.hresetn, .lnk(scu_link_if_i.dev), .channel_idle_flag, .fault_code,
		.volume, .safety_en, .left_port_enable, .right_port_enable, .audio_chan_mask,
		.audio_fmt, .audio_tx_fmt, .audio_rx_fmt, .silence_mask, .silence_len);
	scu_link_assertions scu_link_assertions_i (.hresetn, .link_clk(scu_link_if_i.link_clk),
		.sel_n(scu_link_if_i.sel_n), .cmd_din(scu_link_if_i.cmd_din),
		.rsp_dout(scu_link_if_i.rsp_dout),
		.status_out_pin_one(scu_link_if_i.status_out_pin_one),
		.status_out_pin_two(scu_link_if_i.status_out_pin_two));

	always #20 hclk = !hclk;

	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_errors++;
			complete_run();
		end
	end

	task automatic chk(input bit ok, input string m);
		samples_checked++;
		if (!ok)
		begin
			n_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk

	task automatic ahb(input bit wr, input logic [3:0] off, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {28'h0, off};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	// returns the status word once the frame has left the host
	task automatic cmd(input logic [3:0] op, input logic [3:0] m, input logic [7:0] d,
		output logic [31:0] st);
		int n;
		ahb(1'b1, `SCU_HREG_CMD, {16'h0, op, m, d}, st);
		n = 0;
		do
		begin
			ahb(1'b0, `SCU_HREG_STAT, 32'h0, st);
			n++;
		end
		while (st[0] !== 1'b0 && n < 600);
		chk(n < 600, "command stuck busy");
	endtask : cmd

	task automatic refuse(input logic [3:0] op, input logic [3:0] m, input logic [7:0] d);
		logic [31:0] st;
		cmd(op, m, d, st);
		chk(st[`SCU_STAT_REFUSED] === 1'b1, "command not refused");
		ahb(1'b1, `SCU_HREG_STAT, 32'h2, st);
	endtask : refuse

	task automatic s_reset();
		chk({volume, safety_en, left_port_enable, right_port_enable} === 34'h0, "reset");
	endtask : s_reset

	task automatic s_volume();
		logic [31:0] st;
		cmd(`SCU_OP_VOL, 4'h5, 8'h33, st);
		chk(volume[0] === 7'h33 && volume[2] === 7'h33, "named volume");
		chk(volume[1] === 7'h00 && volume[3] === 7'h00, "unnamed volume");
		refuse(`SCU_OP_VOL, 4'h0, 8'h7f);
		cmd(`SCU_OP_VOL, 4'h2, 8'h11, st);
		chk(volume === {7'h00, 7'h33, 7'h11, 7'h33}, "second volume");
	endtask : s_volume

	task automatic s_safety();
		logic [31:0] st;
		cmd(`SCU_OP_SAFE, 4'h0, 8'h01, st);
		chk(safety_en === 4'h1, "watchdog start");
		refuse(`SCU_OP_SAFE, 4'h0, 8'h03);
		chk(safety_en === 4'h1, "safety after pair");
		cmd(`SCU_OP_SAFE, 4'h0, 8'h02, st);
		chk(safety_en === 4'h2, "fault reset start");
	endtask : s_safety

	task automatic s_readback();
		logic [31:0] st;
		cmd(`SCU_OP_RSTAT, 4'h0, 8'h00, st);
		chk(st[15:8] === 8'h0f && st[19:16] === 4'hf, "status read");
		cmd(`SCU_OP_RVER, 4'h0, 8'h00, st);
		chk(st[15:8] === 8'h5a, "version read");
		cmd(`SCU_OP_RERR, 4'h0, 8'h00, st);
		chk(st[15:8] === 8'h00 && st[2] === 1'b0, "error read");
	endtask : s_readback

	task automatic s_audio();
		logic [31:0] st;
		refuse(`SCU_OP_SIL, 4'h1, 8'h40);
		cmd(`SCU_OP_AFMT, 4'h0, 8'h05, st);
		chk(audio_fmt === scu_fmt_t'(8'h05) && audio_clk_en === 1'b1, "format");
		cmd(`SCU_OP_ATX, 4'h0, 8'h9a, st);
		cmd(`SCU_OP_ARX, 4'h0, 8'h9a, st);
		chk(audio_tx_fmt === scu_fmt_t'(8'h9a) && audio_rx_fmt === scu_fmt_t'(8'h9a), "tx rx");
		cmd(`SCU_OP_SIL, 4'h1, 8'h40, st);
		chk(silence_mask === 4'h1 && silence_len === 8'h40, "silence");
		refuse(`SCU_OP_ACH, 4'h1, 8'h02);
		channel_idle_flag <= 4'h7;
		cmd(`SCU_OP_RSTAT, 4'h0, 8'h00, st);
		refuse(`SCU_OP_ACH, 4'h2, 8'h02);
		channel_idle_flag <= 4'hf;
		cmd(`SCU_OP_RSTAT, 4'h0, 8'h00, st);
		cmd(`SCU_OP_ACH, 4'h2, 8'h02, st);
		chk(left_port_enable === 1'b1 && right_port_enable === 1'b0, "left on");
		chk(audio_chan_mask === 4'h2, "audio mask");
		refuse(`SCU_OP_AFMT, 4'h0, 8'h11);
		chk(audio_fmt === scu_fmt_t'(8'h05), "format while on");
		cmd(`SCU_OP_ACH, 4'h2, 8'h01, st);
		chk(left_port_enable === 1'b0 && right_port_enable === 1'b1, "right on");
	endtask : s_audio

	// fault mode on the status pins: a non-empty fault read must not be retried
	task automatic s_status();
		logic [31:0] st;
		cmd(`SCU_OP_OSEL, 4'h0, 8'h01, st);
		fault_code <= 8'h21;
		cmd(`SCU_OP_RERR, 4'h0, 8'h00, st);
		chk(st[15:8] === 8'h21 && st[21:20] === 2'b11 && st[2] === 1'b0, "fault read");
	endtask : s_status

	initial
	begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		channel_idle_flag = 4'hf;
		fault_code = 8'h00;
		n_errors = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		s_reset();
		s_volume();
		s_safety();
		s_readback();
		s_audio();
		s_status();
		complete_run();
	end
endmodule : speech_cmd_usage_checks_bench
